// ### logic/dsp_params.svh
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH
`define DSP_BOTTOM 16'h0000
`define DSP_TOP_8BIT 16'h00FF
`define DSP_TOP_9BIT 16'h01FF
`define DSP_TOP_10BIT 16'h03FF
`define DSP_MIN_TOP 16'h0003
`define DSP_WGM_PC8 4'h1
`define DSP_WGM_PC9 4'h2
`define DSP_WGM_PC10 4'h3
`define DSP_WGM_PFC_ICR 4'h8
`define DSP_WGM_PFC_OCA 4'h9
`define DSP_WGM_PC_ICR 4'hA
`define DSP_WGM_PC_OCA 4'hB
`define DSP_ADDR_CTRL 12'h000
`define DSP_ADDR_PRESC 12'h004
`define DSP_ADDR_CMPA 12'h008
`define DSP_ADDR_CMPB 12'h00C
`define DSP_ADDR_CAPTOP 12'h010
`define DSP_ADDR_COUNT 12'h014
`define DSP_ADDR_FLAGS 12'h018
`define DSP_ADDR_ACTA 12'h01C
`define DSP_ADDR_ACTB 12'h020
`define DSP_FLAG_OVF 0
`define DSP_FLAG_CMPA 1
`define DSP_FLAG_CMPB 2
`define DSP_FLAG_CAP 3
`define DSP_DIV_1 11'h001
`define DSP_DIV_8 11'h008
`define DSP_DIV_64 11'h040
`define DSP_DIV_256 11'h100
`define DSP_DIV_1024 11'h400
`define DSP_RESP_OKAY 2'h0
`define DSP_RESP_SLVERR 2'h2
`endif

// ### logic/dsp_pkg.sv
package dsp_pkg;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} dsp_wreq_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic aw_got;
		logic w_got;
		logic [11:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [3:0] wgm;
		logic [1:0] act_a;
		logic [1:0] act_b;
		logic [2:0] presc;
		logic [10:0] div_cnt;
		logic [15:0] count;
		logic down;
		logic [15:0] cmpa;
		logic [15:0] cmpb;
		logic [15:0] cmpa_buf;
		logic [15:0] cmpb_buf;
		logic [15:0] captop;
		logic [3:0] flags;
		logic [1:0] wave;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic [1:0] dir_pin;
		logic [1:0] dir_meta;
		logic [1:0] port_val_s;
		logic [1:0] port_val_meta;
	} dsp_state_type;
endpackage

// ### logic/dsp_timer.sv
//
// Behaviour
// - phase correct TOP: fixed FF/1FF/3FF for codes 1-3, capture 10, compare A 11.
// - counter runs bottom to TOP and back in both dual-slope modes.
// - counter stays at TOP for one enable before counting down.
// - phase correct sets overflow flag when counter reaches bottom.
// - phase correct buffer load at TOP sets compare A flag in code 11, capture flag in code 10, neither in codes 1-3.
// - compare flag sets when the counter steps onto its compare value in a dual-slope mode.
// - fixed TOP masks compare bits above resolution on write.
// - action 10 gives non-inverted PWM, 11 gives inverted.
// - non-inverted clears on up-count match, sets on down-count match.
// - wave reaches pin only when pin direction is output.
// - phase correct, action 10: compare at bottom gives low, at TOP high; action 11 the reverse.
// - code 11 with action 1 toggles output A, fifty percent duty.
// - phase-frequency TOP from capture for code 8, compare A for 9.
// - phase-frequency loads compare buffers and sets overflow at bottom.
// - phase-frequency sets compare A or capture flag at TOP.
// - code 9 with action 1 toggles output A, fifty percent duty.
// - phase-frequency, action 10: compare at bottom low, at TOP high; action 11 the reverse.
// - counter advances only on prescaler enables of 1,8,64,256,1024.
// - action 01 toggles output A only in codes 9 or 11, else disconnected.
// - compare writes go to a buffer copied at the mode update point.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`include "dsp_params.svh"
module dsp_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] wave_pin_direction,
	input wire logic [1:0] port_out_value,
	output logic [1:0] wave_pin_out,
	output logic [1:0] wave_pin_oe
);
	dsp_pkg::dsp_state_type st_r;
	dsp_pkg::dsp_state_type st_nxt;

	function automatic logic is_dual(input logic [3:0] m);
		is_dual = (m == `DSP_WGM_PC8) || (m == `DSP_WGM_PC9) || (m == `DSP_WGM_PC10) ||
			(m == `DSP_WGM_PFC_ICR) || (m == `DSP_WGM_PFC_OCA) ||
			(m == `DSP_WGM_PC_ICR) || (m == `DSP_WGM_PC_OCA);
	endfunction

	// all-ones mask for fixed TOP modes, else full width
	function automatic logic [15:0] fixed_mask(input logic [3:0] m);
		case (m)
			`DSP_WGM_PC8: fixed_mask = `DSP_TOP_8BIT;
			`DSP_WGM_PC9: fixed_mask = `DSP_TOP_9BIT;
			`DSP_WGM_PC10: fixed_mask = `DSP_TOP_10BIT;
			default: fixed_mask = 16'hFFFF;
		endcase
	endfunction

	function automatic logic top_is_oca(input logic [3:0] m);
		top_is_oca = (m == `DSP_WGM_PC_OCA) || (m == `DSP_WGM_PFC_OCA);
	endfunction

	function automatic logic top_is_cap(input logic [3:0] m);
		top_is_cap = (m == `DSP_WGM_PC_ICR) || (m == `DSP_WGM_PFC_ICR);
	endfunction

	function automatic logic [10:0] div_of(input logic [2:0] p);
		case (p)
			3'h1: div_of = `DSP_DIV_1;
			3'h2: div_of = `DSP_DIV_8;
			3'h3: div_of = `DSP_DIV_64;
			3'h4: div_of = `DSP_DIV_256;
			3'h5: div_of = `DSP_DIV_1024;
			default: div_of = 11'h000;
		endcase
	endfunction

	logic [15:0] top_val;
	logic tick;
	logic pfc_mode;
	logic dual;
	logic at_top;
	logic at_bot;
	logic [1:0] match;
	logic [1:0] wave_en;
	logic [31:0] rd_data;
	logic rd_ok;
	logic wr_ok;
	logic [15:0] wr16;
	logic [1:0] ev;
	logic [3:0] fset;

	always_comb begin
		dual = is_dual(st_r.wgm);
		pfc_mode = (st_r.wgm == `DSP_WGM_PFC_ICR) || (st_r.wgm == `DSP_WGM_PFC_OCA);
		// fixed TOP or register TOP
		if (top_is_oca(st_r.wgm)) begin
			top_val = st_r.cmpa;
		end else if (top_is_cap(st_r.wgm)) begin
			top_val = st_r.captop;
		end else begin
			top_val = fixed_mask(st_r.wgm);
		end
		// counter moves only on a prescaler enable
		tick = (div_of(st_r.presc) != 11'h000) &&
			(st_r.div_cnt == div_of(st_r.presc) - 11'h001);
		at_top = (st_r.count == top_val);
		at_bot = (st_r.count == `DSP_BOTTOM);
		match[0] = (st_r.count == st_r.cmpa);
		match[1] = (st_r.count == st_r.cmpb);
		rd_ok = 1'b1;
		case (st_r.aw_addr)
			default: wr_ok = 1'b0;
			`DSP_ADDR_CTRL, `DSP_ADDR_PRESC, `DSP_ADDR_CMPA, `DSP_ADDR_CMPB,
			`DSP_ADDR_CAPTOP, `DSP_ADDR_COUNT, `DSP_ADDR_FLAGS,
			`DSP_ADDR_ACTA, `DSP_ADDR_ACTB: wr_ok = 1'b1;
		endcase
		wr16 = st_r.w_data[15:0];
		case (s_axi_araddr)
			`DSP_ADDR_CTRL: rd_data = {28'h0000000, st_r.wgm};
			`DSP_ADDR_PRESC: rd_data = {29'h0000000, st_r.presc};
			`DSP_ADDR_CMPA: rd_data = {16'h0000, st_r.cmpa_buf};
			`DSP_ADDR_CMPB: rd_data = {16'h0000, st_r.cmpb_buf};
			`DSP_ADDR_CAPTOP: rd_data = {16'h0000, st_r.captop};
			`DSP_ADDR_COUNT: rd_data = {16'h0000, st_r.count};
			`DSP_ADDR_FLAGS: rd_data = {28'h0000000, st_r.flags};
			`DSP_ADDR_ACTA: rd_data = {30'h0000000, st_r.act_a};
			`DSP_ADDR_ACTB: rd_data = {30'h0000000, st_r.act_b};
			default: begin
				rd_data = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// events kept apart so a same-cycle clear cannot undo them
		fset = 4'h0;
		ev = 2'h0;
		st_nxt.dir_meta = wave_pin_direction;
		st_nxt.dir_pin = st_r.dir_meta;
		st_nxt.port_val_meta = port_out_value;
		st_nxt.port_val_s = st_r.port_val_meta;
		st_nxt.div_cnt = tick || (div_of(st_r.presc) == 11'h000) ? 11'h000 :
			st_r.div_cnt + 11'h001;
		// counting and events
		if (dual && tick) begin
			if (!st_r.down) begin
				// turn in the same step, so TOP and BOTTOM each last one enable
				if (at_top) begin
					st_nxt.down = 1'b1;
					st_nxt.count = st_r.count - 16'h0001;
				end else begin
					st_nxt.count = st_r.count + 16'h0001;
				end
			end else begin
				if (at_bot) begin
					st_nxt.down = 1'b0;
					st_nxt.count = st_r.count + 16'h0001;
				end else begin
					st_nxt.count = st_r.count - 16'h0001;
				end
			end
			// flags on arrival at TOP or BOTTOM, compare on arrival at value
			if (st_nxt.count != st_r.count) begin
				if (st_nxt.count == `DSP_BOTTOM) begin
					fset[`DSP_FLAG_OVF] = 1'b1;
					if (pfc_mode) begin
						st_nxt.cmpa = st_r.cmpa_buf;
						st_nxt.cmpb = st_r.cmpb_buf;
					end
				end
				if (st_nxt.count == top_val) begin
					if (!pfc_mode) begin
						st_nxt.cmpa = st_r.cmpa_buf;
						st_nxt.cmpb = st_r.cmpb_buf;
					end
					if (top_is_oca(st_r.wgm)) begin
						fset[`DSP_FLAG_CMPA] = 1'b1;
					end
					if (top_is_cap(st_r.wgm)) begin
						fset[`DSP_FLAG_CAP] = 1'b1;
					end
				end
				ev[0] = (st_nxt.count == st_nxt.cmpa);
				ev[1] = (st_nxt.count == st_nxt.cmpb);
				fset[`DSP_FLAG_CMPA] = fset[`DSP_FLAG_CMPA] | ev[0];
				fset[`DSP_FLAG_CMPB] = fset[`DSP_FLAG_CMPB] | ev[1];
				// going up next means st_nxt.count > old; equal to TOP counts as up
				if (ev[0]) begin
					case (st_r.act_a)
						2'h1: begin
							if (top_is_oca(st_r.wgm)) begin
								st_nxt.wave[0] = ~st_r.wave[0];
							end
						end
						2'h2: st_nxt.wave[0] = st_nxt.down;
						2'h3: st_nxt.wave[0] = ~st_nxt.down;
						default: st_nxt.wave[0] = st_r.wave[0];
					endcase
				end
				if (ev[1]) begin
					case (st_r.act_b)
						2'h2: st_nxt.wave[1] = st_nxt.down;
						2'h3: st_nxt.wave[1] = ~st_nxt.down;
						default: st_nxt.wave[1] = st_r.wave[1];
					endcase
				end
			end
		end
		st_nxt.flags = st_r.flags | fset;
		// extremes: bottom keeps level low, TOP keeps it high (non-inverted)
		for (int i = 0; i < 2; i++) begin
			if (dual && ((i == 0 ? st_r.act_a : st_r.act_b) >= 2'h2)) begin
				if ((i == 0 ? st_r.cmpa : st_r.cmpb) == `DSP_BOTTOM) begin
					st_nxt.wave[i] = ((i == 0 ? st_r.act_a : st_r.act_b) == 2'h3);
				end else if ((i == 0 ? st_r.cmpa : st_r.cmpb) == top_val) begin
					st_nxt.wave[i] = ((i == 0 ? st_r.act_a : st_r.act_b) == 2'h2);
				end
			end
		end
		// axi write
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
			st_nxt.wready = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wr_ok ? `DSP_RESP_OKAY : `DSP_RESP_SLVERR;
			if (st_r.w_strb[0]) begin
				case (st_r.aw_addr)
					`DSP_ADDR_CTRL: begin
						st_nxt.wgm = wr16[3:0];
						if (is_dual(wr16[3:0]) && (wr16[3:0] != st_r.wgm)) begin
							st_nxt.down = 1'b0;
						end
					end
					`DSP_ADDR_PRESC: st_nxt.presc = wr16[2:0];
					`DSP_ADDR_ACTA: st_nxt.act_a = wr16[1:0];
					`DSP_ADDR_ACTB: st_nxt.act_b = wr16[1:0];
					// write one to clear; a same-cycle event still wins
					`DSP_ADDR_FLAGS: st_nxt.flags = (st_r.flags & ~wr16[3:0]) | fset;
					default: st_nxt.flags = st_nxt.flags;
				endcase
			end
			if (st_r.w_strb[1:0] == 2'h3) begin
				case (st_r.aw_addr)
					`DSP_ADDR_CMPA: st_nxt.cmpa_buf = wr16 & fixed_mask(st_r.wgm);
					`DSP_ADDR_CMPB: st_nxt.cmpb_buf = wr16 & fixed_mask(st_r.wgm);
					`DSP_ADDR_CAPTOP: st_nxt.captop = wr16;
					`DSP_ADDR_COUNT: st_nxt.count = wr16;
					default: st_nxt.captop = st_nxt.captop;
				endcase
			end
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready = 1'b1;
		end
		// axi read
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_data;
			st_nxt.rresp = rd_ok ? `DSP_RESP_OKAY : `DSP_RESP_SLVERR;
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
		// pins: wave only when connected and pin set as output
		wave_en[0] = dual && ((st_r.act_a[1]) || (st_r.act_a == 2'h1 && top_is_oca(st_r.wgm)));
		wave_en[1] = dual && st_r.act_b[1];
		for (int j = 0; j < 2; j++) begin
			st_nxt.pin_oe[j] = st_r.dir_pin[j];
			st_nxt.pin_out[j] = wave_en[j] ? st_r.wave[j] : st_r.port_val_s[j];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign wave_pin_out = st_r.pin_out;
	assign wave_pin_oe = st_r.pin_oe;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	count_range_a: assert property (dual && !st_r.down && !at_top && tick && st_r.count < top_val
		&& !(st_r.aw_got && st_r.w_got) |=> st_r.count == $past(st_r.count) + 16'h0001)
		else $error("counter did not step up");
	top_hold_a: assert property (dual && tick && at_top && !st_r.down && !(st_r.aw_got && st_r.w_got)
		|=> st_r.down && st_r.count == $past(st_r.count) - 16'h0001)
		else $error("counter did not turn at TOP");
	no_tick_a: assert property (!tick && !(st_r.aw_got && st_r.w_got) |=> $stable(st_r.count))
		else $error("counter moved without enable");
	ovf_flag_a: assert property (dual && $changed(st_r.count) && st_r.count == `DSP_BOTTOM
		&& !$past(st_r.aw_got && st_r.w_got) |-> st_r.flags[`DSP_FLAG_OVF])
		else $error("overflow flag missing at bottom");
	cmp_flag_a: assert property (dual && $changed(st_r.count) && st_r.count == st_r.cmpb
		&& !$past(st_r.aw_got && st_r.w_got) |-> st_r.flags[`DSP_FLAG_CMPB])
		else $error("compare flag missing");
	// three flops from pin to enable; reset must not sit inside the window
	pin_dir_a: assert property (##3 1 |-> wave_pin_oe == $past(wave_pin_direction, 3))
		else $error("pin enable not from direction");
	pfc_load_a: assert property (pfc_mode && $changed(st_r.count) && st_r.count != `DSP_BOTTOM
		&& !$past(st_r.aw_got && st_r.w_got) |-> $stable(st_r.cmpa))
		else $error("compare loaded away from bottom");
	bottom_level_a: assert property (dual && st_r.act_a[1] && st_r.cmpa == `DSP_BOTTOM
		|=> st_r.wave[0] == ($past(st_r.act_a) == 2'h3))
		else $error("bottom compare level wrong");
	mask_bits_a: assert property (st_r.aw_got && st_r.w_got && !st_r.bvalid &&
		st_r.aw_addr == `DSP_ADDR_CMPA && st_r.w_strb[1:0] == 2'h3
		|=> (st_r.cmpa_buf & ~fixed_mask(st_r.wgm)) == 16'h0000)
		else $error("compare bits above resolution kept");
	bot_turn_a: assert property (dual && tick && at_bot && st_r.down && !(st_r.aw_got && st_r.w_got)
		|=> !st_r.down && st_r.count == $past(st_r.count) + 16'h0001)
		else $error("counter did not turn at bottom");
	flag_hold_a: assert property (!(st_r.aw_got && st_r.w_got)
		|=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
		else $error("flag cleared without a write");
	pin_wave_a: assert property (dual && st_r.act_b[1]
		|=> wave_pin_out[1] == $past(st_r.wave[1]))
		else $error("wave B not on its pin");
	mode_up_a: assert property (st_r.aw_got && st_r.w_got && !st_r.bvalid &&
		st_r.aw_addr == `DSP_ADDR_CTRL && st_r.w_strb[0] && is_dual(st_r.w_data[3:0]) &&
		st_r.w_data[3:0] != st_r.wgm |=> !st_r.down)
		else $error("new mode did not count up");

	top_cov_c: cover property (dual && tick && at_top && !st_r.down);
	bot_cov_c: cover property (dual && st_r.flags[`DSP_FLAG_OVF]);
	tog_cov_c: cover property (top_is_oca(st_r.wgm) && st_r.act_a == 2'h1 && $changed(st_r.wave[0]));
	rd_cov_c: cover property (st_r.rvalid && s_axi_rready);
	pfc_cov_c: cover property (pfc_mode && tick && at_bot && st_r.down);
endmodule // dsp_timer

// ### dv/dsp_load.sv
module dsp_load (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	output logic [1:0] level,
	output logic [1:0][15:0] per,
	output logic [1:0][15:0] hi
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] prev_r;
	logic [1:0] flt_r;
	logic [1:0][15:0] cnt_r;
	logic [1:0][15:0] hcnt_r;
	// a released pin has no pull: it shows the inverse of its last driven level
	assign level = (pin_oe & pin_out) | (~pin_oe & flt_r);
	always_ff @(posedge aclk) begin
		flt_r <= !aresetn ? 2'h0 : (pin_oe & ~pin_out) | (~pin_oe & flt_r);
		prev_r <= level;
		for (int i = 0; i < 2; i++) begin
			if (!aresetn) begin
				cnt_r[i] <= 16'h0000;
				hcnt_r[i] <= 16'h0000;
				per[i] <= 16'h0000;
				hi[i] <= 16'h0000;
			end else if (level[i] && !prev_r[i]) begin
				per[i] <= cnt_r[i] + 16'h0001;
				hi[i] <= hcnt_r[i];
				cnt_r[i] <= 16'h0000;
				hcnt_r[i] <= 16'h0001;
			end else begin
				cnt_r[i] <= cnt_r[i] + 16'h0001;
				hcnt_r[i] <= hcnt_r[i] + {15'h0000, level[i]};
			end
		end
	end
endmodule // dsp_load

// ### dv/tb.sv
`include "dsp_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [3:0] m;
		logic [2:0] p;
		logic [15:0] top, ca, cb;
		logic [1:0] aa, ab;
		logic [15:0] pa, ha, pb, hb;
	} dsp_row_type;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, dir, port, pout, poe, lvl;
	logic [1:0][15:0] per, hi;
	logic [15:0] msk [3] = '{`DSP_TOP_8BIT, `DSP_TOP_9BIT, `DSP_TOP_10BIT};
	logic [3:0] fmode [2] = '{`DSP_WGM_PC_ICR, `DSP_WGM_PFC_ICR};
	int errors, n_checks;
	// tops stay at or above 0x0003 and at or above every compare value
	dsp_row_type rows [9] = '{
		'{4'hA, 3'h1, 16'h0064, 16'h001E, 16'h0046, 2'h2, 2'h2, 16'h00C8, 16'h003C, 16'h00C8, 16'h008C},
		'{4'hA, 3'h1, 16'h0064, 16'h001E, 16'h0046, 2'h3, 2'h3, 16'h00C8, 16'h008C, 16'h00C8, 16'h003C},
		'{4'h8, 3'h1, 16'h0040, 16'h0010, 16'h0030, 2'h2, 2'h0, 16'h0080, 16'h0020, 16'h0000, 16'h0000},
		'{4'h1, 3'h1, 16'h0000, 16'h0080, 16'h0000, 2'h2, 2'h0, 16'h01FE, 16'h0100, 16'h0000, 16'h0000},
		'{4'hA, 3'h2, 16'h0008, 16'h0002, 16'h0000, 2'h2, 2'h0, 16'h0080, 16'h0020, 16'h0000, 16'h0000},
		'{4'hB, 3'h1, 16'h0000, 16'h0028, 16'h0000, 2'h1, 2'h0, 16'h00A0, 16'h0050, 16'h0000, 16'h0000},
		'{4'h9, 3'h1, 16'h0000, 16'h0028, 16'h0000, 2'h1, 2'h0, 16'h00A0, 16'h0050, 16'h0000, 16'h0000},
		'{4'hA, 3'h1, 16'h0064, 16'h0000, 16'h0064, 2'h2, 2'h2, 16'h0000, 16'h0000, 16'h0000, 16'h0001},
		'{4'hA, 3'h1, 16'h0064, 16'h001E, 16'h0000, 2'h1, 2'h1, 16'h0000, 16'h0001, 16'h0000, 16'h0000}
	};
	dsp_timer u_dsp_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wave_pin_direction(dir), .port_out_value(port),
		.wave_pin_out(pout), .wave_pin_oe(poe));
	dsp_load u_dsp_load (.aclk(aclk), .aresetn(aresetn), .pin_out(pout), .pin_oe(poe),
		.level(lvl), .per(per), .hi(hi));
	task automatic end_of_test();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ad, wd;
		@(posedge aclk);
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic run(input dsp_row_type r);
		wr(`DSP_ADDR_PRESC, 32'h0); // TOP only changes while stopped
		wr(`DSP_ADDR_COUNT, 32'h0);
		wr(`DSP_ADDR_CTRL, {28'h0, r.m});
		wr(`DSP_ADDR_CAPTOP, {16'h0, r.top});
		wr(`DSP_ADDR_CMPA, {16'h0, r.ca});
		wr(`DSP_ADDR_CMPB, {16'h0, r.cb});
		wr(`DSP_ADDR_ACTA, {30'h0, r.aa});
		wr(`DSP_ADDR_ACTB, {30'h0, r.ab});
		wr(`DSP_ADDR_PRESC, {29'h0, r.p});
		repeat (3 * r.pa + 3 * r.pb + 600) @(posedge aclk);
		if (r.pa != 16'h0) begin
			chk(per[0], r.pa);
			chk(hi[0], r.ha);
		end else
			chk(lvl[0], r.ha);
		if (r.pb != 16'h0) begin
			chk(per[1], r.pb);
			chk(hi[1], r.hb);
		end else
			chk(lvl[1], r.hb);
	endtask
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		repeat (40000) @(posedge aclk);
		errors++;
		end_of_test();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 60'h0;
		dir = 2'h3;
		port = 2'h1;
		errors = 0;
		n_checks = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i])
			run(rows[i]);
		wr(`DSP_ADDR_PRESC, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(`DSP_ADDR_CTRL, i + 1);
			wr(`DSP_ADDR_CMPA, 32'h0000FFFF);
			rdr(`DSP_ADDR_CMPA);
			chk(rd, {16'h0, msk[i]});
		end
		// both update points raise every flag once compares sit inside the slope
		for (int i = 0; i < 2; i++) begin
			wr(`DSP_ADDR_COUNT, 32'h0);
			wr(`DSP_ADDR_CTRL, {28'h0, fmode[i]});
			wr(`DSP_ADDR_CAPTOP, 32'h14);
			wr(`DSP_ADDR_CMPA, 32'h5);
			wr(`DSP_ADDR_CMPB, 32'h5);
			wr(`DSP_ADDR_FLAGS, 32'hF);
			wr(`DSP_ADDR_PRESC, 32'h1);
			repeat (200) @(posedge aclk);
			wr(`DSP_ADDR_PRESC, 32'h0);
			rdr(`DSP_ADDR_FLAGS);
			chk(rd, 32'hF);
			wr(`DSP_ADDR_FLAGS, 32'hF);
			rdr(`DSP_ADDR_FLAGS);
			chk(rd, 32'h0);
		end
		wr(12'h100, 32'h1);
		chk(rs, `DSP_RESP_SLVERR);
		rdr(12'h100);
		chk(rs, `DSP_RESP_SLVERR);
		chk(rd, 32'h0);
		dir <= 2'h0;
		repeat (5) @(posedge aclk);
		chk(poe, 2'h0);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({awready, wready, arready, bvalid, rvalid, pout}, 7'h70);
		aresetn <= 1'b1;
		rdr(`DSP_ADDR_CTRL);
		chk(rd, 32'h0);
		rdr(`DSP_ADDR_COUNT);
		chk(rd, 32'h0);
		rdr(`DSP_ADDR_FLAGS);
		chk(rd, 32'h0);
		end_of_test();
	end
endmodule // tb
